/* rtl/sink_driver_consts.svh */
`ifndef SINK_DRIVER_CONSTS_SVH
`define SINK_DRIVER_CONSTS_SVH

// ==========================================================================
// Structure
// ==========================================================================
`define SD_STAGES 8
`define SD_STAGE_RESET 1'b0

// ==========================================================================
// Timing
// ==========================================================================
`define SD_REF_CLK_MHZ 25
`define SD_SCLK_MAX_MHZ 10
`define SD_SCLK_MIN_PERIOD_NS 100
// Least serial clock period in reference cycles, rounded up.
`define SD_SCLK_MIN_CYCLES ((`SD_SCLK_MIN_PERIOD_NS * `SD_REF_CLK_MHZ + 999) / 1000)
// Each half period is rounded up again, so the full period never undercuts the limit.
`define SD_SCLK_HALF_CYCLES ((`SD_SCLK_MIN_CYCLES + 1) / 2)
`define SD_STROBE_CYCLES 2

`endif

/* rtl/sink_driver_device.sv */
`timescale 1ns/1ps
`include "sink_driver_consts.svh"

// ==========================================================================
// One stage: shift flip-flop, storage latch and sink driver
// ==========================================================================
module sink_stage
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Shift chain
    input wire logic shiftRise,
    input wire logic prevBit,
    output logic stageBit,
    // Latch and driver controls
    input wire logic latchOpen,
    input wire logic outputsOff,
    output logic sinkOn
);
    logic stage_ff;
    logic latch_ff;
    logic sink_ff;
    logic nxt_stage;
    logic nxt_latch;
    logic nxt_sink;

    always_comb
    begin
        // Without a rising serial clock edge the stage keeps its bit.
        nxt_stage = stage_ff; // see RULE_14
        if (shiftRise)
        begin
            nxt_stage = prevBit; // see RULE_02
        end
        // The latch follows the stage value of this very edge while open, so a
        // strobe that overlaps a shift already carries the new bit.
        nxt_latch = latch_ff; // see RULE_06
        if (latchOpen)
        begin
            nxt_latch = nxt_stage; // see RULE_05
        end
        // Disable only masks the driver; stage and latch are untouched.
        nxt_sink = nxt_latch & ~outputsOff; // see RULE_08
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage_ff <= `SD_STAGE_RESET; // see RULE_11
            latch_ff <= `SD_STAGE_RESET; // see RULE_11
            sink_ff <= 1'b0;
        end
        else
        begin
            stage_ff <= nxt_stage;
            latch_ff <= nxt_latch; // see RULE_09
            sink_ff <= nxt_sink; // see RULE_10
        end
    end

    assign stageBit = stage_ff;
    assign sinkOn = sink_ff;
endmodule

// ==========================================================================
// Serial-in latched sink driver, device end
// ==========================================================================
// Operation
// RULE_01: Eight shift stages, latches, drivers, matched one-to-one.
// RULE_02: Rising serial clock loads input, shifts stages.
// RULE_03: Last stage drives the serial data output.
// RULE_04: Host sets data before the capturing edge.
// RULE_05: Strobe high: latches follow their stages.
// RULE_06: Strobe low: latches hold their contents.
// RULE_07: Strobe tied high: host disables outputs while shifting.
// RULE_08: Disable high turns all sinks off.
// RULE_09: Disable never alters stages or latches.
// RULE_10: Disable low: each sink follows its latch.
// RULE_11: Power-on clears every stage and latch.
// RULE_12: Serial output chains into another device.
// RULE_13: Host keeps serial clock at most 10 MHz.
// RULE_14: No rising edge: stages and output unchanged.
// RULE_15: Strobe and disable are level-sensitive controls.
module sink_driver_device #(
    parameter int STAGES = `SD_STAGES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link to the host
    sink_link_if.device link,
    // Sink outputs, high while the sink conducts; bit 0 is the first output
    output logic [STAGES-1:0] sinkOutput
);
    // ======================================================================
    // Serial clock edge detection
    // ======================================================================
    // The serial clock is sampled as a synchronous input; a rising edge is a
    // low sample followed by a high one. This limits the serial clock to at most
    // half the reference rate, which the host end respects by design.
    logic clkPrev_ff;
    logic nxt_clkPrev;
    logic shiftRise;

    always_comb
    begin
        nxt_clkPrev = link.serialClk;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clkPrev_ff <= 1'b0;
        end
        else
        begin
            clkPrev_ff <= nxt_clkPrev;
        end
    end

    assign shiftRise = link.serialClk & ~clkPrev_ff; // see RULE_02

    // ======================================================================
    // Stage array
    // ======================================================================
    // Stage one is bit 0 and takes the serial input; each further stage takes
    // the one before it.
    logic [STAGES-1:0] stageBits;
    logic [STAGES-1:0] chainIn;

    assign chainIn = {stageBits[STAGES-2:0], link.serialIn}; // see RULE_02

    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi++)
        begin : gen_stage
            // Strobe and disable are levels, applied on every reference cycle.
            sink_stage u_stage // see RULE_01
            (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .shiftRise(shiftRise),
                .prevBit(chainIn[gi]),
                .stageBit(stageBits[gi]),
                .latchOpen(link.latchTransparent), // see RULE_15
                .outputsOff(link.outputDisable), // see RULE_15
                .sinkOn(sinkOutput[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Serial data output
    // ======================================================================
    // The last stage is itself a flip-flop, so the output needs no extra
    // register and chained devices see it one reference cycle after the edge.
    assign link.serialOut = stageBits[STAGES-1]; // see RULE_03 see RULE_12
endmodule

/* rtl/sink_driver_host.sv */
`timescale 1ns/1ps
`include "sink_driver_consts.svh"

// ==========================================================================
// Serial-in latched sink driver, host end
// ==========================================================================
module sink_driver_host #(
    parameter int WORD_BITS = `SD_STAGES,
    parameter int BUF_DEPTH = 2,
    parameter int HALF_CYCLES = `SD_SCLK_HALF_CYCLES,
    parameter int STROBE_CYCLES = `SD_STROBE_CYCLES,
    parameter bit LATCH_BYPASS = 1'b0
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Words to send, most significant bit shifted first
    input wire logic [WORD_BITS-1:0] wordData,
    input wire logic wordValid,
    output logic wordReady,
    // Output control and status
    input wire logic disableReq,
    output logic busy,
    // Link to the device
    sink_link_if.host link
);
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(WORD_BITS + 1);

    // ======================================================================
    // Word buffer
    // ======================================================================
    logic [WORD_BITS-1:0] bufMem_ff [BUF_DEPTH];
    logic [PTR_W-1:0] wrPtr_ff;
    logic [PTR_W-1:0] rdPtr_ff;
    logic [PTR_W:0] fill_ff;
    logic [PTR_W-1:0] nxt_wrPtr;
    logic [PTR_W-1:0] nxt_rdPtr;
    logic [PTR_W:0] nxt_fill;
    logic push;
    logic pop;
    logic bufValid;

    assign bufValid = (fill_ff != '0);
    assign push = wordValid & wordReady;

    always_comb
    begin
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        nxt_fill = fill_ff;
        if (push)
        begin
            nxt_wrPtr = (wrPtr_ff == PTR_W'(BUF_DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
        end
        if (pop)
        begin
            nxt_rdPtr = (rdPtr_ff == PTR_W'(BUF_DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_fill = fill_ff + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_fill = fill_ff - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            fill_ff <= '0;
            wordReady <= 1'b0;
            for (int i = 0; i < BUF_DEPTH; i++)
            begin
                bufMem_ff[i] <= '0;
            end
        end
        else
        begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            fill_ff <= nxt_fill;
            // Ready is registered from the next fill, so the word that fills the
            // buffer drops it at the same edge and no word can be offered into a full one.
            wordReady <= (nxt_fill < (PTR_W + 1)'(BUF_DEPTH));
            if (push)
            begin
                bufMem_ff[wrPtr_ff] <= wordData;
            end
        end
    end

    // ======================================================================
    // Shift sequencer
    // ======================================================================
    sink_driver_pkg::host_state_t state_ff;
    sink_driver_pkg::host_state_t nxt_state;
    sink_driver_pkg::timer_t timer_ff;
    sink_driver_pkg::timer_t nxt_timer;
    logic [WORD_BITS-1:0] shift_ff;
    logic [WORD_BITS-1:0] nxt_shift;
    logic [CNT_W-1:0] bitCnt_ff;
    logic [CNT_W-1:0] nxt_bitCnt;
    logic sclk_ff;
    logic nxt_sclk;
    logic sdata_ff;
    logic nxt_sdata;
    logic strobe_ff;
    logic nxt_strobe;
    logic disable_ff;
    logic nxt_disable;
    logic busy_ff;
    logic nxt_busy;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_shift = shift_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_sclk = sclk_ff;
        nxt_sdata = sdata_ff;
        nxt_strobe = LATCH_BYPASS;
        pop = 1'b0;
        unique case (state_ff)
            sink_driver_pkg::HOST_IDLE:
            begin
                if (bufValid)
                begin
                    pop = 1'b1;
                    nxt_shift = bufMem_ff[rdPtr_ff];
                    nxt_sdata = bufMem_ff[rdPtr_ff][WORD_BITS-1];
                    nxt_bitCnt = '0;
                    nxt_timer = sink_driver_pkg::timer_t'(HALF_CYCLES - 1);
                    nxt_state = sink_driver_pkg::HOST_CLK_LOW;
                end
            end
            sink_driver_pkg::HOST_CLK_LOW:
            begin
                // Data has stood a full low half before the rising edge.
                if (timer_ff == '0)
                begin
                    nxt_sclk = 1'b1; // see RULE_04 see RULE_13
                    nxt_timer = sink_driver_pkg::timer_t'(HALF_CYCLES - 1);
                    nxt_state = sink_driver_pkg::HOST_CLK_HIGH;
                end
                else
                begin
                    nxt_timer = timer_ff - 1'b1;
                end
            end
            sink_driver_pkg::HOST_CLK_HIGH:
            begin
                if (timer_ff == '0)
                begin
                    nxt_sclk = 1'b0; // see RULE_13
                    nxt_timer = sink_driver_pkg::timer_t'(HALF_CYCLES - 1);
                    if (bitCnt_ff == CNT_W'(WORD_BITS - 1))
                    begin
                        nxt_timer = sink_driver_pkg::timer_t'(STROBE_CYCLES - 1);
                        nxt_strobe = 1'b1;
                        nxt_state = sink_driver_pkg::HOST_STROBE;
                    end
                    else
                    begin
                        nxt_shift = {shift_ff[WORD_BITS-2:0], 1'b0};
                        nxt_sdata = shift_ff[WORD_BITS-2]; // see RULE_12
                        nxt_bitCnt = bitCnt_ff + 1'b1;
                        nxt_state = sink_driver_pkg::HOST_CLK_LOW;
                    end
                end
                else
                begin
                    nxt_timer = timer_ff - 1'b1;
                end
            end
            sink_driver_pkg::HOST_STROBE:
            begin
                nxt_strobe = 1'b1;
                if (timer_ff == '0)
                begin
                    nxt_strobe = LATCH_BYPASS;
                    nxt_state = sink_driver_pkg::HOST_IDLE;
                end
                else
                begin
                    nxt_timer = timer_ff - 1'b1;
                end
            end
        endcase
        nxt_busy = (nxt_state != sink_driver_pkg::HOST_IDLE);
        // With the latches bypassed the sinks would show every shift step.
        nxt_disable = disableReq | (LATCH_BYPASS & nxt_busy); // see RULE_07
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= sink_driver_pkg::HOST_IDLE;
            timer_ff <= '0;
            shift_ff <= '0;
            bitCnt_ff <= '0;
            sclk_ff <= 1'b0;
            sdata_ff <= 1'b0;
            strobe_ff <= 1'b0;
            disable_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            shift_ff <= nxt_shift;
            bitCnt_ff <= nxt_bitCnt;
            sclk_ff <= nxt_sclk;
            sdata_ff <= nxt_sdata;
            strobe_ff <= nxt_strobe;
            disable_ff <= nxt_disable;
            busy_ff <= nxt_busy;
        end
    end

    assign link.serialClk = sclk_ff;
    assign link.serialIn = sdata_ff;
    assign link.latchTransparent = strobe_ff;
    assign link.outputDisable = disable_ff;
    assign busy = busy_ff;
endmodule

/* rtl/sink_driver_pkg.sv */
package sink_driver_pkg;

    typedef enum logic [1:0]
    {
        HOST_IDLE,
        HOST_CLK_LOW,
        HOST_CLK_HIGH,
        HOST_STROBE
    } host_state_t;

    typedef logic [3:0] timer_t;

endpackage

/* rtl/sink_link_if.sv */
`timescale 1ns/1ps

interface sink_link_if;
    logic serialClk;
    logic serialIn;
    logic serialOut;
    logic latchTransparent;
    logic outputDisable;

    modport device
    (
        input serialClk,
        input serialIn,
        input latchTransparent,
        input outputDisable,
        output serialOut
    );

    modport host
    (
        output serialClk,
        output serialIn,
        output latchTransparent,
        output outputDisable,
        input serialOut
    );
endinterface

/* test/sink_driver_assertions.sv */
`timescale 1ns/1ps

// ==========================================================================
// Link checker
// ==========================================================================
module sink_driver_assertions #(
    parameter int STAGES = 8
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link signals
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic latchTransparent,
    input wire logic outputDisable,
    // Sink outputs
    input wire logic [STAGES-1:0] sinkOutput
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    a_reset_clear: assert property
        ($rose(arst_n) |-> sinkOutput == '0 && !serialOut)
        else $error("Outputs not clear after reset");
    a_disable_off: assert property
        ($past(outputDisable) && $past(outputDisable, 2) |-> sinkOutput == '0)
        else $error("Sinks on while disabled");
    // The sink may lag its cause by up to two cycles, so the window looks back that far.
    a_latch_hold: assert property
        ($changed(sinkOutput) |-> $past(latchTransparent) || $past(latchTransparent, 2)
            || $past(outputDisable) != $past(outputDisable, 2)
            || $past(outputDisable, 2) != $past(outputDisable, 3))
        else $error("Sinks changed with latches closed");
    a_shift_on_rise: assert property
        ($changed(serialOut) |-> $past(serialClk) && !$past(serialClk, 2))
        else $error("Serial output moved without a clock rise");
    a_clk_high_hold: assert property
        ($rose(serialClk) |=> serialClk)
        else $error("Serial clock high phase too short");
    a_clk_low_hold: assert property
        ($fell(serialClk) |=> !serialClk)
        else $error("Serial clock low phase too short");
    a_entry_dark: assert property
        ($rose(serialClk) |-> outputDisable || !latchTransparent)
        else $error("Shifting with latches open and sinks live");
    a_data_setup: assert property
        ($rose(serialClk) |-> $stable(serialIn))
        else $error("Serial data moved at the clock rise");
endmodule

/* test/test_serial_in_latched_sink_driver.sv */
`timescale 1ns/1ps

// ==========================================================================
// Bench for the host and device ends facing each other
// ==========================================================================
module test_serial_in_latched_sink_driver;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] wordData = 8'h00;
    logic wordValid = 1'b0;
    logic disableReq = 1'b0;
    logic wordReady;
    logic busy;
    logic [7:0] sinkOutput;
    logic [7:0] sinkOutput2;
    logic [7:0] sinkOutput3;
    logic wordReady3;
    logic busy3;
    logic [7:0] model;
    logic [7:0] q;
    logic [7:0] keep;
    logic sawFull;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    sink_link_if link ();
    sink_link_if link2 ();
    sink_link_if link3 ();

    sink_driver_host sink_driver_host_inst
    (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .wordData(wordData),
        .wordValid(wordValid),
        .wordReady(wordReady),
        .disableReq(disableReq),
        .busy(busy),
        .link(link)
    );
    sink_driver_device sink_driver_device_inst
    (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .link(link),
        .sinkOutput(sinkOutput)
    );
    // The second device is bit-banged directly, to reach orders the host never makes.
    sink_driver_device sink_driver_device_inst2
    (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .link(link2),
        .sinkOutput(sinkOutput2)
    );
    // A bypassing host keeps the strobe high, so it must blank the sinks itself.
    sink_driver_host #(
        .LATCH_BYPASS(1'b1)
    ) sink_driver_host_inst2
    (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .wordData(wordData),
        .wordValid(wordValid),
        .wordReady(wordReady3),
        .disableReq(disableReq),
        .busy(busy3),
        .link(link3)
    );
    sink_driver_device sink_driver_device_inst3
    (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .link(link3),
        .sinkOutput(sinkOutput3)
    );
    sink_driver_assertions sink_driver_assertions_inst
    (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .serialClk(link.serialClk),
        .serialIn(link.serialIn),
        .serialOut(link.serialOut),
        .latchTransparent(link.latchTransparent),
        .outputDisable(link.outputDisable),
        .sinkOutput(sinkOutput)
    );

    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end

    // ======================================================================
    // Helpers
    // ======================================================================
    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] shifted(input logic [7:0] r, input logic b);
        return {r[6:0], b};
    endfunction

    function automatic logic [7:0] image(input logic [7:0] w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--)
            r = shifted(r, w[i]);
        return r;
    endfunction

    task automatic send(input logic [7:0] w);
        wordData <= w;
        wordValid <= 1'b1;
        @(negedge ref_clk);
        while (wordReady !== 1'b1)
        begin
            sawFull = 1'b1;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask

    task automatic settle();
        int quiet;
        quiet = 0;
        for (int i = 0; i < 400 && quiet < 4; i++)
        begin
            @(negedge ref_clk);
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
            if (link3.serialClk === 1'b1)
                chk("outputDisable3", {7'h00, link3.outputDisable}, 8'h01);
        end
        @(posedge ref_clk);
    endtask

    task automatic bang(input logic b);
        link2.serialIn <= b;
        repeat (2) @(posedge ref_clk);
        link2.serialClk <= 1'b1;
        repeat (2) @(posedge ref_clk);
        link2.serialClk <= 1'b0;
        model = shifted(model, b);
        @(negedge ref_clk);
        chk("serialOut2", {7'h00, link2.serialOut}, {7'h00, model[7]});
        @(posedge ref_clk);
    endtask

    task automatic host_word(input logic [7:0] w);
        send(w);
        wordValid <= 1'b0;
        settle();
        chk("sinkOutput", sinkOutput, image(w));
        chk("serialOut", {7'h00, link.serialOut}, {7'h00, w[7]});
        chk("sinkOutput3", sinkOutput3, image(w));
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial
    begin
        link2.serialClk = 1'b0;
        link2.serialIn = 1'b0;
        link2.latchTransparent = 1'b0;
        link2.outputDisable = 1'b0;
        void'($urandom(34418));
        model = 8'h00;
        sawFull = 1'b0;
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        chk("sinkOutput", sinkOutput, 8'h00);
        chk("serialOut", {7'h00, link.serialOut}, 8'h00);
        @(posedge ref_clk);
        foreach (q[i])
            host_word(8'h01 << i);
        host_word(8'hff);
        host_word(8'h00);
        repeat (12)
            host_word(8'($urandom));
        keep = sinkOutput;
        disableReq <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("sinkOutput", sinkOutput, 8'h00);
        disableReq <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk("sinkOutput", sinkOutput, keep);
        sawFull = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            q = 8'($urandom);
            send(q);
        end
        wordValid <= 1'b0;
        settle();
        chk("sawFull", {7'h00, sawFull}, 8'h01);
        chk("sinkOutput", sinkOutput, image(q));
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("sinkOutput", sinkOutput, 8'h00);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        for (int r = 0; r < 4; r++)
        begin
            q = 8'($urandom);
            for (int i = 7; i >= 0; i--)
                bang(q[i]);
            link2.latchTransparent <= 1'b1;
            repeat (3) @(posedge ref_clk);
            chk("sinkOutput2", sinkOutput2, q);
            keep = q;
            link2.latchTransparent <= 1'b0;
            // The first round shifts in the complement, so every latch must resist a change.
            q = (r == 0) ? ~keep : 8'($urandom);
            for (int i = 7; i >= 0; i--)
                bang(q[i]);
            chk("sinkOutput2", sinkOutput2, keep);
            repeat (6) @(posedge ref_clk) link2.serialIn <= 1'($urandom);
            @(negedge ref_clk);
            chk("serialOut2", {7'h00, link2.serialOut}, {7'h00, model[7]});
            @(posedge ref_clk);
            link2.latchTransparent <= 1'b1;
            bang(q[0]);
            repeat (3) @(posedge ref_clk);
            chk("sinkOutput2", sinkOutput2, model);
            keep = model;
            link2.latchTransparent <= 1'b0;
            link2.outputDisable <= 1'b1;
            bang(~q[1]);
            repeat (2) @(posedge ref_clk);
            chk("sinkOutput2", sinkOutput2, 8'h00);
            link2.outputDisable <= 1'b0;
            repeat (3) @(posedge ref_clk);
            chk("sinkOutput2", sinkOutput2, keep);
        end
        wrap_up();
    end
endmodule
